/* File: bench/dpl_dac_model.sv */
// Behavioural model of the double-buffered DAC parallel input
`timescale 1ns/1ps
module dpl_dac_model (
   input wire logic        chip_select_n,
   input wire logic        write_n,
   input wire logic        nibble_addr_bit0,
   input wire logic        nibble_addr_bit1,
   input wire logic [7:0]  dac_data,
   input wire logic        load_converter_n,
   input wire logic        clear_n,
   output logic     [11:0] dac_latch
);
   logic [11:0] input_latch;
   initial begin
      input_latch = 12'h000;
      dac_latch   = 12'h000;
   end
   // Selected nibbles follow the pins while select and write are low
   always @* begin
      if (!chip_select_n && !write_n) begin
         case ({nibble_addr_bit0, nibble_addr_bit1})
            2'h3: input_latch[11:8] = dac_data[3:0];
            2'h2: input_latch[7:4]  = dac_data[7:4];
            2'h1: input_latch[3:0]  = dac_data[3:0];
            default: input_latch[7:0] = dac_data;
         endcase
      end
   end
   // Clear wins over everything and needs no strobe or select
   always @* begin
      if (!clear_n)
         dac_latch = 12'h000;
      else if (!load_converter_n)
         dac_latch = input_latch;
   end
endmodule : dpl_dac_model

/* File: bench/dpl_host_assertions.sv */
// Concurrent checks on the DAC host controller pins and bus answers
`timescale 1ns/1ps
module dpl_host_assertions #(
   parameter int STROBE_CYC = 2
) (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       chip_select_n,
   input wire logic       write_n,
   input wire logic       nibble_addr_bit0,
   input wire logic       nibble_addr_bit1,
   input wire logic [7:0] dac_data,
   input wire logic       load_converter_n
);
   // ------
   // Helpers
   // ------
   int low_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         low_cnt <= 0;
      else if (!write_n)
         low_cnt <= low_cnt + 1;
      else
         low_cnt <= 0;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------
   // Properties
   // ------
   property p_strobe_width;
      $rose(write_n) |-> low_cnt == STROBE_CYC;
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe width");
   property p_cs_setup;
      $fell(chip_select_n) |-> write_n ##1 !write_n;
   endproperty
   a_cs_setup: assert property (p_cs_setup) else $error("no setup cycle before write");
   property p_write_in_select;
      !write_n |-> !chip_select_n;
   endproperty
   a_write_in_select: assert property (p_write_in_select) else $error("stray write");
   property p_rise_together;
      $rose(write_n) |-> $rose(chip_select_n);
   endproperty
   a_rise_together: assert property (p_rise_together) else $error("split rise");
   property p_sub_lsb_zero;
      !write_n && !nibble_addr_bit0 |-> dac_data[1:0] == 2'h0;
   endproperty
   a_sub_lsb_zero: assert property (p_sub_lsb_zero) else $error("sub bits not zero");
   property p_pins_stable;
      !write_n && !$past(write_n) |-> $stable({dac_data, nibble_addr_bit1, nibble_addr_bit0});
   endproperty
   a_pins_stable: assert property (p_pins_stable) else $error("pins moved in strobe");
   property p_load_hold;
      $rose(write_n) && !load_converter_n |=> !load_converter_n;
   endproperty
   a_load_hold: assert property (p_load_hold) else $error("load strobe released early");
   property p_bvalid_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
   property p_read_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule : dpl_host_assertions

/* File: bench/tb_dac_parallel_load_interface.sv */
// Self-checking bench for the DAC host controller
`timescale 1ns/1ps
`include "dpl_defines.svh"
module tb_dac_parallel_load_interface;
   localparam int STROBE_CYC = 2;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, chip_select_n, write_n, nibble_addr_bit0, nibble_addr_bit1;
   logic        load_converter_n, clear_n, wr_prev;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, dac_data;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, first_adr, last_adr;
   logic [11:0] dac_latch;
   int          num_errors, checks, cycles, wr_cnt;
   dpl_host #(.STROBE_CYC(STROBE_CYC)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .chip_select_n(chip_select_n), .write_n(write_n), .nibble_addr_bit0(nibble_addr_bit0),
      .nibble_addr_bit1(nibble_addr_bit1), .dac_data(dac_data),
      .load_converter_n(load_converter_n), .clear_n(clear_n));
   dpl_dac_model u_dac (
      .chip_select_n(chip_select_n), .write_n(write_n), .nibble_addr_bit0(nibble_addr_bit0),
      .nibble_addr_bit1(nibble_addr_bit1), .dac_data(dac_data),
      .load_converter_n(load_converter_n), .clear_n(clear_n), .dac_latch(dac_latch));
   initial aclk = 1'b0;
   always #50 aclk = ~aclk;
   // ------
   // Write-cycle monitor and timeout
   // ------
   always @(posedge aclk) begin
      wr_prev <= write_n;
      cycles <= cycles + 1;
      if (!write_n)
         last_adr <= {nibble_addr_bit1, nibble_addr_bit0};
      if (!write_n && wr_prev === 1'b1) begin
         if (wr_cnt == 0)
            first_adr <= {nibble_addr_bit1, nibble_addr_bit0};
         wr_cnt <= wr_cnt + 1;
      end
      if (cycles == 20000) begin
         num_errors++;
         $display("unexpected at %0t: timeout", $time);
         test_done();
      end
   end
   // ------
   // Tasks
   // ------
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask : check_val
   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: response %h, wanted %h", $time, got, exp);
      end
   endtask : check_resp
   // Each task starts one edge after the last, so no strobe is set twice in a step
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : axi_read
   task automatic wait_done();
      logic [31:0] st;
      logic [1:0]  r;
      do
         axi_read(`DPL_STATUS_OFS, st, r);
      while (st[`DPL_STAT_DONE_BIT] !== 1'b1);
   endtask : wait_done
   function automatic logic [31:0] exp_first(input int mode, input int ord);
      if (mode == 0)
         return 32'h2;
      return (mode == 1 && ord == 1) ? 32'h3 : 32'h0;
   endfunction : exp_first
   task automatic load_and_check(input int mode, input int ord, input logic [9:0] code);
      logic [31:0] rd;
      logic [1:0]  rsp;
      axi_write(`DPL_CTRL_OFS, 32'(mode) | 32'(ord << 2), rsp);
      axi_write(`DPL_STATUS_OFS, 32'h4, rsp);
      wr_cnt = 0;
      axi_write(`DPL_CODE_OFS, {22'h0, code}, rsp);
      wait_done();
      check_val({20'h0, dac_latch}, {20'h0, code, 2'h0});
      check_val(32'(wr_cnt), (mode == 0) ? 32'h3 : 32'h2);
      check_val({30'h0, first_adr}, exp_first(mode, ord));
      check_val({30'h0, last_adr}, (mode == 1 && ord == 1) ? 32'h0 : 32'h3);
      axi_read(`DPL_LASTCODE_OFS, rd, rsp);
      check_val(rd, {22'h0, code});
   endtask : load_and_check
   // ------
   // Main sequence
   // ------
   initial begin
      logic [31:0] rd;
      logic [1:0]  rsp;
      int unsigned seed;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      {num_errors, checks, cycles, wr_cnt} = {32'h0, 32'h0, 32'h0, 32'h0};
      wr_prev = 1'b1;
      seed = $urandom(32'h3f54);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(`DPL_CTRL_OFS, rd, rsp);
      check_val(rd, 32'h0);
      check_val({20'h0, dac_latch}, 32'h0);
      axi_read(8'h10, rd, rsp);
      check_resp(rsp, 2'h2);
      check_val(rd, 32'h0);
      axi_write(8'h14, 32'h1, rsp);
      check_resp(rsp, 2'h2);
      for (int i = 0; i < 18; i++)
         load_and_check(i % 3, (i / 3) % 2, (i < 2) ? {10{i[0]}} : 10'($urandom));
      // Second code while busy is dropped
      axi_write(`DPL_CTRL_OFS, 32'h1, rsp);
      axi_write(`DPL_STATUS_OFS, 32'h4, rsp);
      wr_cnt = 0;
      axi_write(`DPL_CODE_OFS, 32'h2a5, rsp);
      axi_write(`DPL_CODE_OFS, 32'h15a, rsp);
      wait_done();
      repeat (40) @(posedge aclk);
      check_val({20'h0, dac_latch}, {20'h0, 10'h2a5, 2'h0});
      check_val(32'(wr_cnt), 32'h2);
      // Clear zeroes the converter and blocks loads
      axi_write(`DPL_STATUS_OFS, 32'h4, rsp);
      axi_write(`DPL_CTRL_OFS, 32'h9, rsp);
      axi_read(`DPL_STATUS_OFS, rd, rsp);
      check_val(rd, 32'h2);
      check_val({20'h0, dac_latch}, 32'h0);
      wr_cnt = 0;
      axi_write(`DPL_CODE_OFS, 32'h155, rsp);
      repeat (20) @(posedge aclk);
      check_val(32'(wr_cnt), 32'h0);
      axi_write(`DPL_CTRL_OFS, 32'h1, rsp);
      axi_read(`DPL_STATUS_OFS, rd, rsp);
      check_val(rd, 32'h0);
      check_val({20'h0, dac_latch}, 32'h0);
      test_done();
   end
endmodule : tb_dac_parallel_load_interface

bind dpl_host dpl_host_assertions #(.STROBE_CYC(STROBE_CYC)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .chip_select_n(chip_select_n), .write_n(write_n),
   .nibble_addr_bit0(nibble_addr_bit0), .nibble_addr_bit1(nibble_addr_bit1),
   .dac_data(dac_data), .load_converter_n(load_converter_n));

/* File: common/dpl_defines.svh */
// Constants for the parallel-load DAC host controller
`ifndef DPL_DEFINES_SVH
`define DPL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define DPL_CTRL_OFS      8'h00
`define DPL_CODE_OFS      8'h04
`define DPL_STATUS_OFS    8'h08
`define DPL_LASTCODE_OFS  8'h0c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DPL_CTRL_MODE_LSB   0
`define DPL_CTRL_ORDER_BIT  2
`define DPL_CTRL_CLEAR_BIT  3
`define DPL_STAT_BUSY_BIT   0
`define DPL_STAT_CLEAR_BIT  1
`define DPL_STAT_DONE_BIT   2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DPL_CTRL_RESET    4'h0
`define DPL_CODE_RESET    10'h000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DPL_CLK_PERIOD_NS     100
`define DPL_LOAD_HOLD_NS      50
`define DPL_LOAD_HOLD_CYC     ((`DPL_LOAD_HOLD_NS + `DPL_CLK_PERIOD_NS - 1) / `DPL_CLK_PERIOD_NS)
`define DPL_STROBE_CYC        2

`endif

/* File: common/dpl_pkg.sv */
// Types for the parallel-load DAC host controller
package dpl_pkg;

   // Loading schemes
   typedef enum logic [1:0] {
      DPL_MODE_NIBBLES  = 2'b00,
      DPL_MODE_BYTE_LDL = 2'b01,
      DPL_MODE_BYTE_LDT = 2'b10
   } dpl_mode_t;

   // Sequencer states, Gray in the listed order
   typedef enum logic [2:0] {
      DPL_ST_IDLE   = 3'b000,
      DPL_ST_SETUP  = 3'b001,
      DPL_ST_STROBE = 3'b011,
      DPL_ST_NEXT   = 3'b010,
      DPL_ST_LOAD   = 3'b110,
      DPL_ST_HOLD   = 3'b111
   } dpl_state_t;

endpackage : dpl_pkg

/* File: src/dpl_axil_slave.sv */
// AXI4-Lite register slave for the DAC host controller
`timescale 1ns/1ps
`include "dpl_defines.svh"

module dpl_axil_slave (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [3:0]       ctrl_reg,
   output logic [9:0]       code_reg,
   output logic             go_pulse,
   input  wire logic [2:0]  status_in,
   input  wire logic [9:0]  last_code_in,
   output logic             done_clr
);

   logic [7:0] aw_addr_reg;
   logic       aw_have_reg;
   logic [3:0] w_strb_reg;
   logic [31:0] w_data_reg;
   logic       w_have_reg;
   logic       do_write;
   logic       aw_hit;

   assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign aw_hit   = (aw_addr_reg == `DPL_CTRL_OFS) || (aw_addr_reg == `DPL_CODE_OFS) ||
                     (aw_addr_reg == `DPL_STATUS_OFS);

   // ----------------------------------------------------------------------------
   // Write channels, taken in either order
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= aw_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `DPL_CTRL_RESET;
         code_reg <= `DPL_CODE_RESET;
         go_pulse <= 1'b0;
         done_clr <= 1'b0;
      end else begin
         go_pulse <= 1'b0;
         done_clr <= 1'b0;
         if (do_write && aw_addr_reg == `DPL_CTRL_OFS && w_strb_reg[0]) begin
            ctrl_reg <= w_data_reg[3:0];
         end
         // Writing the code word starts a transfer
         if (do_write && aw_addr_reg == `DPL_CODE_OFS) begin
            if (w_strb_reg[0]) code_reg[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1]) code_reg[9:8] <= w_data_reg[9:8];
            go_pulse <= 1'b1;
         end
         // Write one to the done bit to clear it
         if (do_write && aw_addr_reg == `DPL_STATUS_OFS && w_strb_reg[0] &&
             w_data_reg[`DPL_STAT_DONE_BIT]) begin
            done_clr <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Read channel, one cycle after the address is taken
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
               `DPL_CTRL_OFS:     s_axi_rdata <= {28'h0000000, ctrl_reg};
               `DPL_CODE_OFS:     s_axi_rdata <= {22'h000000, code_reg};
               `DPL_STATUS_OFS:   s_axi_rdata <= {29'h00000000, status_in};
               `DPL_LASTCODE_OFS: s_axi_rdata <= {22'h000000, last_code_in};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : dpl_axil_slave

/* File: src/dpl_host.sv */
// Host controller that loads a double-buffered parallel DAC over its pins
`timescale 1ns/1ps
`include "dpl_defines.svh"

module dpl_host #(
   parameter int STROBE_CYC = `DPL_STROBE_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             chip_select_n,
   output logic             write_n,
   output logic             nibble_addr_bit0,
   output logic             nibble_addr_bit1,
   output logic [7:0]       dac_data,
   output logic             load_converter_n,
   output logic             clear_n
);

   localparam int HOLD_CYC = `DPL_LOAD_HOLD_CYC;

   logic [3:0]           ctrl_reg;
   logic [9:0]           code_reg;
   logic                 go_pulse;
   logic                 done_clr;
   logic [2:0]           status_vec;
   logic [9:0]           last_code_reg;
   logic                 done_reg;
   logic [11:0]          word_reg;
   logic [1:0]           step_reg;
   logic [1:0]           nsteps;
   logic [7:0]           cnt_reg;
   dpl_pkg::dpl_state_t  state_reg;
   dpl_pkg::dpl_mode_t   mode;
   logic                 order_hi_first;
   logic                 busy;
   logic                 cnt_done;
   logic [1:0]           sel;

   assign mode           = dpl_pkg::dpl_mode_t'(ctrl_reg[`DPL_CTRL_MODE_LSB +: 2]);
   assign order_hi_first = ctrl_reg[`DPL_CTRL_ORDER_BIT];
   assign busy           = (state_reg != dpl_pkg::DPL_ST_IDLE);
   assign cnt_done       = (cnt_reg == 8'h00);
   assign status_vec     = {done_reg, ~clear_n, busy};
   assign nsteps         = (mode == dpl_pkg::DPL_MODE_NIBBLES) ? 2'd3 : 2'd2;

   dpl_axil_slave u_regs (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .ctrl_reg      (ctrl_reg),
      .code_reg      (code_reg),
      .go_pulse      (go_pulse),
      .status_in     (status_vec),
      .last_code_in  (last_code_reg),
      .done_clr      (done_clr)
   );

   // ----------------------------------------------------------------------------
   // Nibble selection per step
   // ----------------------------------------------------------------------------
   // sel: 3 = high, 2 = middle, 1 = low, 0 = low plus middle (bit0, bit1)
   always_comb begin
      sel = 2'b11;
      if (mode == dpl_pkg::DPL_MODE_NIBBLES) begin
         case (step_reg)
            2'd0:    sel = 2'b01;
            2'd1:    sel = 2'b10;
            default: sel = 2'b11;
         endcase
      end else if (mode == dpl_pkg::DPL_MODE_BYTE_LDT) begin
         sel = (step_reg == 2'd0) ? 2'b00 : 2'b11;
      end else begin
         // Either order is fine while the load strobe stays high
         sel = ((step_reg == 2'd0) ^ order_hi_first) ? 2'b00 : 2'b11;
      end
   end

   // ----------------------------------------------------------------------------
   // Clear pin
   // ----------------------------------------------------------------------------
   // Driven low from reset so the converter sits in its zero, low-current state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clear_n <= 1'b0;
      end else begin
         clear_n <= !ctrl_reg[`DPL_CTRL_CLEAR_BIT];
      end
   end

   // ----------------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg        <= dpl_pkg::DPL_ST_IDLE;
         step_reg         <= 2'd0;
         cnt_reg          <= 8'h00;
         word_reg         <= 12'h000;
         chip_select_n    <= 1'b1;
         write_n          <= 1'b1;
         nibble_addr_bit0 <= 1'b1;
         nibble_addr_bit1 <= 1'b1;
         dac_data         <= 8'h00;
         load_converter_n <= 1'b1;
      end else begin
         case (state_reg)
            dpl_pkg::DPL_ST_IDLE: begin
               chip_select_n    <= 1'b1;
               write_n          <= 1'b1;
               load_converter_n <= (mode == dpl_pkg::DPL_MODE_BYTE_LDT) ? 1'b0 : 1'b1;
               if (go_pulse && clear_n) begin
                  word_reg  <= {code_reg, 2'b00};
                  step_reg  <= 2'd0;
                  state_reg <= dpl_pkg::DPL_ST_SETUP;
               end
            end
            dpl_pkg::DPL_ST_SETUP: begin
               nibble_addr_bit0 <= sel[1];
               nibble_addr_bit1 <= sel[0];
               case (sel)
                  2'b11:   dac_data <= {4'h0, word_reg[11:8]};
                  // Tied four-bit bus: middle latch reads 7:4, low latch 3:0
                  2'b10:   dac_data <= {word_reg[7:4], word_reg[7:4]};
                  2'b01:   dac_data <= {word_reg[3:0], word_reg[3:0]};
                  default: dac_data <= word_reg[7:0];
               endcase
               chip_select_n <= 1'b0;
               cnt_reg       <= 8'(STROBE_CYC - 1);
               state_reg     <= dpl_pkg::DPL_ST_STROBE;
            end
            dpl_pkg::DPL_ST_STROBE: begin
               write_n <= 1'b0;
               if (!write_n) begin
                  if (cnt_done) begin
                     write_n       <= 1'b1;
                     chip_select_n <= 1'b1;
                     state_reg     <= dpl_pkg::DPL_ST_NEXT;
                  end else begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end
               end
            end
            dpl_pkg::DPL_ST_NEXT: begin
               if (step_reg == nsteps - 2'd1) begin
                  cnt_reg   <= 8'(HOLD_CYC - 1);
                  state_reg <= (mode == dpl_pkg::DPL_MODE_BYTE_LDT) ?
                               dpl_pkg::DPL_ST_HOLD : dpl_pkg::DPL_ST_LOAD;
               end else begin
                  step_reg  <= step_reg + 2'd1;
                  state_reg <= dpl_pkg::DPL_ST_SETUP;
               end
            end
            dpl_pkg::DPL_ST_LOAD: begin
               load_converter_n <= 1'b0;
               if (!load_converter_n) begin
                  if (cnt_done) begin
                     load_converter_n <= 1'b1;
                     state_reg        <= dpl_pkg::DPL_ST_IDLE;
                  end else begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end
               end
            end
            dpl_pkg::DPL_ST_HOLD: begin
               // Strobe stays low past the write rise before any change
               if (cnt_done) begin
                  state_reg <= dpl_pkg::DPL_ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            default: state_reg <= dpl_pkg::DPL_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Last loaded code and done flag
   // ----------------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_code_reg <= 10'h000;
         done_reg      <= 1'b0;
      end else begin
         if (!clear_n) begin
            last_code_reg <= 10'h000;
         end else if (state_reg == dpl_pkg::DPL_ST_LOAD && !load_converter_n && cnt_done) begin
            last_code_reg <= word_reg[11:2];
         end else if (state_reg == dpl_pkg::DPL_ST_HOLD && cnt_done) begin
            last_code_reg <= word_reg[11:2];
         end
         // Set wins over a clear in the same cycle
         if ((state_reg == dpl_pkg::DPL_ST_LOAD && !load_converter_n && cnt_done) ||
             (state_reg == dpl_pkg::DPL_ST_HOLD && cnt_done)) begin
            done_reg <= 1'b1;
         end else if (done_clr) begin
            done_reg <= 1'b0;
         end
      end
   end

endmodule : dpl_host
